/* rtl/mmx_dev.sv */
/*
 Device end: management register bank of the module.
 Assumes monitor values, status flags and checker enables arrive on pclk.
*/
// Chosen here: the mmx_if carrier port.
`timescale 1ns/1ps
`include "mmx_defs.svh"
module mmx_dev #(
    parameter logic [7:0] AUX_IMPL = 8'hFF,
    parameter logic [14:0] MAX_UPG_BLK = `MMX_RST_BLK_SIZE
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    mmx_if.dev bus,
    input wire logic [7:0] aux_alarm_latch,
    input wire logic [15:0] vendor_alarm_latch,
    input wire logic alarm_master_en,
    input wire mmx_pkg::mmx_word_t temp_raw,
    input wire mmx_pkg::mmx_word_t supply_raw,
    input wire mmx_pkg::mmx_word_t bias_raw,
    input wire mmx_pkg::mmx_word_t aux1_raw,
    input wire mmx_pkg::mmx_word_t aux2_raw,
    input wire logic line_chk_en,
    input wire logic host_chk_en,
    input wire logic bit_tick_line,
    input wire logic bit_tick_host,
    input wire logic sec_tick,
    input wire logic upl_block_placed,
    input wire logic upg_block_consumed,
    input wire logic [15:0] upg_status_in,
    input wire logic [3:0] upg_wait_5s,
    input wire mmx_pkg::mmx_word_t ext_status_live,
    output logic upl_start_pulse,
    output mmx_pkg::mmx_cmd_e upg_cmd,
    output logic global_alarm_out
);
    import mmx_pkg::*;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [7:0] aux_en_ff;
    logic [15:0] vnd_en_ff;
    logic [31:0] line_cnt_ff;
    logic [31:0] host_cnt_ff;
    logic [31:0] sec_ff;
    logic [15:0] sec_lo_shadow_ff;
    logic [15:0] upl_ctl_ff;
    logic upl_ready_ff;
    logic [14:0] upl_size_ff;
    logic upg_ready_ff;
    logic [15:0] upg_ctl_ff;
    logic [15:0] latch_ff;
    logic [15:0] ext_en_ff;
    logic [15:0] rdata_ff;
    logic ack_ff;
    logic alarm_ff;
    // Missing sources come out of reset already disabled
    localparam logic [7:0] AUX_EN_RST = 8'(`MMX_RST_AUX_EN) & AUX_IMPL;

    // Floating encode: shift until value fits 10 bits
    function automatic logic [15:0] mmx_float(input logic [31:0] v);
        logic [5:0] e;
        logic [31:0] m;
        e = 6'h00;
        m = v;
        for (int i = 0; i < 22; i++) begin
            if (m > 32'h0000_03FF) begin
                m = m >> 1;
                e = e + 6'h01;
            end
        end
        return {e, m[9:0]};
    endfunction : mmx_float

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire acc = bus.req && clk_en;
    wire wr_en = acc && bus.wr;
    wire rd_en = acc && !bus.wr;
    wire hit_aux_en = bus.addr == `MMX_A_AUX_EN;
    wire hit_vnd_en = bus.addr == `MMX_A_VND_EN;
    wire hit_sec_hi = bus.addr == `MMX_A_SEC_HI;
    wire hit_sec_lo = bus.addr == `MMX_A_SEC_LO;
    wire hit_upl_ctl = bus.addr == `MMX_A_UPL_CTL;
    wire hit_upl_inf = bus.addr == `MMX_A_UPL_INFO;
    wire hit_upg_inf = bus.addr == `MMX_A_UPG_INFO;
    wire hit_upg_ctl = bus.addr == `MMX_A_UPG_CTL;
    wire hit_latch = bus.addr == `MMX_A_EXT_LATCH;
    wire hit_ext_en = bus.addr == `MMX_A_EXT_EN;
    wire [15:0] live = ext_status_live & `MMX_EXT_MASK;
    wire [15:0] stat_word = live;
    wire [15:0] upg_stat = upg_status_in;
    logic [15:0] rd_mux;
    always_comb begin
        if (hit_aux_en) rd_mux = {8'h00, aux_en_ff};
        else if (hit_vnd_en) rd_mux = vnd_en_ff;
        else if (bus.addr == `MMX_A_TEMP) rd_mux = temp_raw;
        else if (bus.addr == `MMX_A_SUPPLY) rd_mux = supply_raw;
        else if (bus.addr == `MMX_A_BIAS) rd_mux = bias_raw;
        else if (bus.addr == `MMX_A_AUX1) rd_mux = aux1_raw;
        else if (bus.addr == `MMX_A_AUX2) rd_mux = aux2_raw;
        else if (bus.addr == `MMX_A_LINE_CNT) rd_mux = mmx_float(line_cnt_ff);
        else if (bus.addr == `MMX_A_HOST_CNT) rd_mux = mmx_float(host_cnt_ff);
        else if (hit_sec_hi) rd_mux = sec_ff[31:16];
        else if (hit_sec_lo) rd_mux = sec_lo_shadow_ff;
        else if (hit_upl_ctl) rd_mux = upl_ctl_ff;
        else if (hit_upl_inf) rd_mux = {upl_ready_ff, upl_size_ff};
        else if (hit_upg_inf) rd_mux = {upg_ready_ff, MAX_UPG_BLK};
        else if (hit_upg_ctl) rd_mux = {upg_ctl_ff[15:12], upg_wait_5s, 8'h00};
        else if (bus.addr == `MMX_A_EXT_STAT) rd_mux = stat_word;
        else if (bus.addr == `MMX_A_UPG_STAT) rd_mux = upg_stat;
        else if (hit_latch) rd_mux = latch_ff;
        else if (hit_ext_en) rd_mux = ext_en_ff;
        else rd_mux = 16'h0000;
    end

    // ----------------------------------------
    // Next values
    // ----------------------------------------
    // Hidden bits forced zero so unimplemented sources never alarm
    wire [7:0] nxt_aux_en = bus.wdata[7:0] & AUX_IMPL;
    wire [15:0] nxt_latch = (rd_en && hit_latch) ? live : (latch_ff | live);
    wire [31:0] nxt_sec = (wr_en && hit_sec_hi) ? {bus.wdata, sec_lo_shadow_ff}
                        : sec_tick ? sec_ff + 32'h1 : sec_ff;
    wire alarm_or = |(aux_en_ff & aux_alarm_latch)
                  | |(vnd_en_ff & vendor_alarm_latch)
                  | |(ext_en_ff & latch_ff);
    wire nxt_alarm = alarm_master_en && alarm_or;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_en_ff <= AUX_EN_RST;
            vnd_en_ff <= `MMX_RST_ZERO;
            line_cnt_ff <= 32'h0000_0000;
            host_cnt_ff <= 32'h0000_0000;
            sec_ff <= 32'h0000_0000;
            sec_lo_shadow_ff <= `MMX_RST_ZERO;
            upl_ctl_ff <= `MMX_RST_ZERO;
            upl_ready_ff <= 1'b0;
            upl_size_ff <= `MMX_RST_BLK_SIZE;
            upg_ready_ff <= 1'b0;
            upg_ctl_ff <= `MMX_RST_ZERO;
            latch_ff <= `MMX_RST_ZERO;
            ext_en_ff <= `MMX_RST_ZERO;
            rdata_ff <= `MMX_RST_ZERO;
            ack_ff <= 1'b0;
            alarm_ff <= 1'b0;
        end else if (clk_en) begin
            ack_ff <= bus.req;
            if (rd_en) rdata_ff <= rd_mux;
            if (wr_en && hit_aux_en) aux_en_ff <= nxt_aux_en[7:0] & AUX_IMPL;
            if (wr_en && hit_vnd_en) vnd_en_ff <= bus.wdata;
            if (line_chk_en && bit_tick_line) line_cnt_ff <= line_cnt_ff + 32'h1;
            if (host_chk_en && bit_tick_host) host_cnt_ff <= host_cnt_ff + 32'h1;
            if (wr_en && hit_sec_lo) sec_lo_shadow_ff <= bus.wdata;
            else if (sec_tick && !(wr_en && hit_sec_hi)) sec_lo_shadow_ff <= nxt_sec[15:0];
            sec_ff <= nxt_sec;
            // Start bit held one cycle only, seen as a pulse
            if (wr_en && hit_upl_ctl) upl_ctl_ff <= {bus.wdata[15:11], 3'b000, bus.wdata[7:0]};
            else upl_ctl_ff[`MMX_BIT_START] <= 1'b0;
            // Placement wins over host clear in the same cycle
            if (upl_block_placed) upl_ready_ff <= 1'b1;
            else if (wr_en && hit_upl_inf) upl_ready_ff <= bus.wdata[15];
            if (wr_en && hit_upl_inf) upl_size_ff <= bus.wdata[14:0];
            if (upg_block_consumed) upg_ready_ff <= 1'b0;
            else if (wr_en && hit_upg_inf && bus.wdata[15]) upg_ready_ff <= 1'b1;
            if (wr_en && hit_upg_ctl) upg_ctl_ff <= {bus.wdata[15:12], 12'h000};
            latch_ff <= nxt_latch;
            if (wr_en && hit_ext_en) ext_en_ff <= bus.wdata & `MMX_EXT_MASK;
            alarm_ff <= nxt_alarm;
        end
    end

    assign bus.ack = ack_ff;
    assign bus.rdata = rdata_ff;
    assign upl_start_pulse = upl_ctl_ff[`MMX_BIT_START];
    assign upg_cmd = mmx_cmd_e'(upg_ctl_ff[15:12]);
    assign global_alarm_out = alarm_ff;
endmodule : mmx_dev

/* rtl/mmx_defs.svh */
/*
 Offsets, field positions, reset values and codes shared by the
 management register bank and its host-side driver.
 Assumes inclusion by bare name from rtl/.
*/
`ifndef MMX_DEFS_SVH
`define MMX_DEFS_SVH
`define MMX_A_AUX_EN 16'hB02C
`define MMX_A_VND_EN 16'hB02D
`define MMX_A_TEMP 16'hB02F
`define MMX_A_SUPPLY 16'hB030
`define MMX_A_BIAS 16'hB031
`define MMX_A_AUX1 16'hB032
`define MMX_A_AUX2 16'hB033
`define MMX_A_LINE_CNT 16'hB038
`define MMX_A_HOST_CNT 16'hB039
`define MMX_A_SEC_HI 16'hB03A
`define MMX_A_SEC_LO 16'hB03B
`define MMX_A_UPL_CTL 16'hB04A
`define MMX_A_UPL_INFO 16'hB04B
`define MMX_A_UPG_INFO 16'hB04C
`define MMX_A_UPG_CTL 16'hB04D
`define MMX_A_EXT_STAT 16'hB050
`define MMX_A_UPG_STAT 16'hB051
`define MMX_A_EXT_LATCH 16'hB054
`define MMX_A_EXT_EN 16'hB057
`define MMX_RST_AUX_EN 16'h00FF
`define MMX_RST_ZERO 16'h0000
`define MMX_RST_BLK_SIZE 15'h0001
`define MMX_EXT_MASK 16'hDF80
`define MMX_BIT_START 15
`define MMX_BIT_READY 15
`define MMX_CMD_HI 15
`define MMX_CMD_LO 12
`define MMX_ERR_HI 12
`define MMX_ERR_LO 11
`define MMX_EXP_HI 15
`define MMX_EXP_LO 10
`define MMX_MAN_HI 9
`define MMX_BIT_UPL_AVAIL 8
`define MMX_BIT_UPL_DONE 7
`define MMX_BIT_MASTER 15
`define MMX_WAIT_UNIT_S 5
`endif

/* rtl/mmx_pkg.sv */
/*
 Types for the management register bank.
 Assumes mmx_defs.svh for numeric constants.
*/
package mmx_pkg;
    typedef enum logic [3:0] {
        MMX_CMD_NONE, MMX_CMD_DL_START, MMX_CMD_DL_DONE, MMX_CMD_RUN_A,
        MMX_CMD_RUN_B, MMX_CMD_ABORT, MMX_CMD_COPY_AB, MMX_CMD_COPY_BA,
        MMX_CMD_COMMIT_A, MMX_CMD_COMMIT_B
    } mmx_cmd_e;
    typedef logic [15:0] mmx_word_t;
    typedef logic [15:0] mmx_addr_t;
endpackage : mmx_pkg

/* rtl/mmx_if.sv */
/*
 Management access carrier between host driver and register bank.
 Single-cycle request, rdata valid with ack one cycle later.
*/
`timescale 1ns/1ps
interface mmx_if;
    logic req;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic ack;
    logic [15:0] rdata;
    modport dev (input req, wr, addr, wdata, output ack, rdata);
    modport host (output req, wr, addr, wdata, input ack, rdata);
endinterface : mmx_if

/* rtl/mmx_host.sv */
/*
 Host end: APB slave holding command registers; drives the management
 carrier one access at a time. Assumes the device answers with ack.
*/
`timescale 1ns/1ps
`include "mmx_defs.svh"
module mmx_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    mmx_if.host bus
);
    import mmx_pkg::*;

    // ----------------------------------------
    // APB map: 0x0 cmd, 0x4 rdata, 0x8 status
    // ----------------------------------------
    typedef enum logic [1:0] {MMX_H_IDLE, MMX_H_REQ, MMX_H_WAIT} mmx_hst_e;
    mmx_hst_e st_ff;
    logic [31:0] cmd_ff;
    logic [15:0] rd_ff;
    logic [31:0] prdata_ff;
    logic go_ff;
    wire setup = psel && !penable && clk_en;
    // Writes land only at the edge that completes the access phase
    wire access = psel && penable && pready && clk_en;
    wire hit_cmd = paddr[11:0] == 12'h000;
    wire hit_rd = paddr[11:0] == 12'h004;
    wire hit_st = paddr[11:0] == 12'h008;
    wire busy = st_ff != MMX_H_IDLE || go_ff;
    // Command word: addr in [31:16], data in [15:0]; offset picks direction
    logic wr_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= MMX_H_IDLE;
            cmd_ff <= 32'h0000_0000;
            rd_ff <= 16'h0000;
            prdata_ff <= 32'h0000_0000;
            go_ff <= 1'b0;
            wr_ff <= 1'b0;
        end else if (clk_en) begin
            if (access && pwrite && !busy && (hit_cmd || hit_st)) begin
                cmd_ff <= pwdata;
                wr_ff <= hit_cmd;
                go_ff <= 1'b1;
            end
            if (setup && !pwrite) begin
                if (hit_rd) prdata_ff <= {16'h0000, rd_ff};
                else if (hit_st) prdata_ff <= {31'h0, busy};
                else if (hit_cmd) prdata_ff <= cmd_ff;
                else prdata_ff <= 32'h0000_0000;
            end
            case (st_ff)
                MMX_H_IDLE: if (go_ff) begin
                    st_ff <= MMX_H_REQ;
                    go_ff <= 1'b0;
                end
                MMX_H_REQ: st_ff <= MMX_H_WAIT;
                MMX_H_WAIT: if (bus.ack) begin
                    rd_ff <= bus.rdata;
                    st_ff <= MMX_H_IDLE;
                end
                default: st_ff <= MMX_H_IDLE;
            endcase
        end
    end

    // Commands, error codes and handshakes are carried as raw words
    assign bus.req = st_ff == MMX_H_REQ;
    assign bus.wr = wr_ff;
    assign bus.addr = cmd_ff[31:16];
    assign bus.wdata = cmd_ff[15:0];
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_ff;
endmodule : mmx_host

/* verification/mmx_assertions.sv */
/*
 Checker for the carrier between host end and register bank.
 Assumes it is instantiated beside the carrier, no bind.
*/
`timescale 1ns/1ps
module mmx_assertions #(
    parameter logic [7:0] AUX_IMPL = 8'hFF,
    parameter logic [14:0] MAX_UPG_BLK = 15'h0001
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire logic wr,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic ack,
    input wire logic [15:0] rdata,
    input wire logic upl_start_pulse
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_rd(a);
        req && !wr && addr == a;
    endsequence
    sequence s_wr(a);
        req && wr && addr == a;
    endsequence
    // Bits outside the mask must read zero
    property p_zero(a, m);
        s_rd(a) |=> ack && (rdata & ~m) == 16'h0000;
    endproperty
    AST_AUX_EN_IMPL: assert property (p_zero(16'hB02C, {8'h00, AUX_IMPL}))
        else $error("aux enable set for a missing source");
    AST_EXT_STAT: assert property (p_zero(16'hB050, 16'hDF80))
        else $error("reserved status bit set");
    AST_EXT_LATCH: assert property (p_zero(16'hB054, 16'hDF80))
        else $error("reserved latch bit set");
    AST_EXT_EN: assert property (p_zero(16'hB057, 16'hDF80))
        else $error("reserved enable bit set");
    AST_UPL_SC: assert property (p_zero(16'hB04A, 16'h78FF))
        else $error("upload start bit did not clear");
    AST_UPG_RSV: assert property (p_zero(16'hB04D, 16'hFF00))
        else $error("upgrade control low byte not zero");
    AST_UPG_BLK: assert property (s_rd(16'hB04C) |=>
        ack && rdata[14:0] == MAX_UPG_BLK)
        else $error("upgrade block size wrong");
    AST_UPL_START: assert property (s_wr(16'hB04A) ##0 wdata[15] |=>
        ##[0:2] upl_start_pulse)
        else $error("upload start pulse missing");
endmodule : mmx_assertions

/* verification/module_mgmt_ext_regs_tb.sv */
/*
 Bench: APB drives the host end, which reaches the bank on the carrier.
 Assumes the bank acks each carrier request one cycle later.
*/
`timescale 1ns/1ps
module module_mgmt_ext_regs_tb;
    import mmx_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata;
    logic pready, pslverr, upl_start, alarm_out, rd_pend = 0;
    logic line_en = 0, host_en = 0, tick_l = 0, tick_h = 0;
    logic placed = 0, used = 0, alarm_en = 0, run_en = 1, sec_tk = 0;
    logic [7:0] aux_latch = 0;
    logic [3:0] wait_5s = 0;
    mmx_word_t mon [5] = '{default: 0};
    mmx_word_t upg_st = 0, ext_live = 0, got, exp_q[$];
    mmx_cmd_e upg_cmd;
    int err_total = 0, num_checks = 0;
    always #12.5 pclk = ~pclk;
    mmx_if bus_if();
    mmx_host mmx_host_inst(.pclk(pclk), .presetn(presetn), .clk_en(run_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(bus_if));
    mmx_dev #(.AUX_IMPL(8'hF0)) mmx_dev_inst(.pclk(pclk),
        .presetn(presetn), .clk_en(run_en), .bus(bus_if),
        .aux_alarm_latch(aux_latch), .vendor_alarm_latch(16'h0000),
        .alarm_master_en(alarm_en), .temp_raw(mon[0]),
        .supply_raw(mon[1]), .bias_raw(mon[2]), .aux1_raw(mon[3]),
        .aux2_raw(mon[4]), .line_chk_en(line_en), .host_chk_en(host_en),
        .bit_tick_line(tick_l), .bit_tick_host(tick_h), .sec_tick(sec_tk),
        .upl_block_placed(placed), .upg_block_consumed(used),
        .upg_status_in(upg_st), .upg_wait_5s(wait_5s),
        .ext_status_live(ext_live), .upl_start_pulse(upl_start),
        .upg_cmd(upg_cmd), .global_alarm_out(alarm_out));
    mmx_assertions #(.AUX_IMPL(8'hF0)) mmx_assertions_inst(.pclk(pclk),
        .presetn(presetn), .req(bus_if.req), .wr(bus_if.wr),
        .addr(bus_if.addr), .wdata(bus_if.wdata), .ack(bus_if.ack),
        .rdata(bus_if.rdata), .upl_start_pulse(upl_start));
    // --------------------------------------------
    // Tasks
    // --------------------------------------------
    task tk(input int n);
        repeat (n) @(posedge pclk);
    endtask : tk
    task chk(input mmx_word_t seen, input mmx_word_t want);
        num_checks++;
        if (seen !== want) begin
            err_total++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask : chk
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        tk(1);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        tk(1);
        penable <= 1;
        // Only the watchdog ends a wait that never completes
        do begin
            tk(1);
        end while (pready !== 1'b1);
        got = prdata[15:0];
        psel <= 0;
        penable <= 0;
    endtask : apb
    // Busy bit polled so a request is never dropped while one is open
    task mm(input logic w, input mmx_addr_t a, input mmx_word_t d);
        apb(1'b1, w ? 32'h0 : 32'h8, {a, d});
        do begin
            apb(1'b0, 32'h8, 32'h0);
        end while (got[0] !== 1'b0);
    endtask : mm
    task rd(input mmx_addr_t a, input mmx_word_t e);
        exp_q.push_back(e);
        mm(1'b0, a, 16'h0000);
    endtask : rd
    task complete_run;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    // Carrier read answers are matched against the oldest note
    always @(posedge pclk) begin
        rd_pend <= bus_if.req === 1'b1 && bus_if.wr === 1'b0;
        if (bus_if.ack === 1'b1 && rd_pend) begin
            if (exp_q.size() == 0) chk(16'hFFFF, 16'h0000);
            else chk(bus_if.rdata, exp_q.pop_front());
        end
    end
    initial begin
        tk(20000);
        err_total++;
        complete_run;
    end
    initial begin
        void'($urandom(84));
        tk(20);
        presetn <= 1;
        rd(16'hB02C, 16'h00F0);
        rd(16'hB057, 16'h0000);
        rd(16'hB054, 16'h0000);
        rd(16'hB02E, 16'h0000);
        mm(1'b1, 16'hB02C, 16'hFFFF);
        rd(16'hB02C, 16'h00F0);
        foreach (mon[i]) mon[i] <= 16'($urandom);
        upg_st <= 16'($urandom);
        wait_5s <= 4'($urandom);
        tk(1);
        for (int i = 0; i < 5; i++) rd(16'(16'hB02F + i), mon[i]);
        aux_latch <= 8'h01;
        alarm_en <= 1;
        tk(4);
        chk({15'h0, alarm_out}, 16'h0000);
        aux_latch <= 8'h80;
        tk(4);
        chk({15'h0, alarm_out}, 16'h0001);
        alarm_en <= 0;
        tk(4);
        chk({15'h0, alarm_out}, 16'h0000);
        alarm_en <= 1;
        mm(1'b1, 16'hB02C, 16'h0000);
        tk(4);
        chk({15'h0, alarm_out}, 16'h0000);
        for (int k = 0; k < 2; k++) begin
            line_en <= k[0];
            host_en <= k[0];
            tick_l <= 1;
            tick_h <= 1;
            tk(5);
            tick_l <= 0;
            tick_h <= 0;
            tk(1);
            rd(16'hB038, 16'(5 * k));
            rd(16'hB039, 16'(5 * k));
        end
        // Ticks while the clock enable is low must not count
        run_en <= 0;
        tick_l <= 1;
        tk(3);
        tick_l <= 0;
        run_en <= 1;
        tk(1);
        rd(16'hB038, 16'h0005);
        mm(1'b1, 16'hB03B, 16'h1234);
        mm(1'b1, 16'hB03A, 16'hABCD);
        rd(16'hB03A, 16'hABCD);
        rd(16'hB03B, 16'h1234);
        sec_tk <= 1;
        tk(1);
        sec_tk <= 0;
        tk(1);
        rd(16'hB03A, 16'hABCD);
        rd(16'hB03B, 16'h1235);
        mm(1'b1, 16'hB04A, 16'h885A);
        rd(16'hB04A, 16'h085A);
        rd(16'hB04B, 16'h0001);
        placed <= 1;
        tk(1);
        placed <= 0;
        tk(1);
        rd(16'hB04B, 16'h8001);
        mm(1'b1, 16'hB04C, 16'h8000);
        rd(16'hB04C, 16'h8001);
        used <= 1;
        tk(1);
        used <= 0;
        tk(1);
        rd(16'hB04C, 16'h0001);
        for (int c = 0; c < 10; c++) begin
            mm(1'b1, 16'hB04D, {c[3:0], 12'h000});
            chk({12'h000, upg_cmd}, 16'(c));
            rd(16'hB04D, {c[3:0], wait_5s, 8'h00});
        end
        rd(16'hB051, upg_st);
        apb(1'b0, 32'h4, 32'h0);
        chk(got, upg_st);
        ext_live <= 16'hFFFF;
        mm(1'b1, 16'hB057, 16'hFFFF);
        rd(16'hB057, 16'hDF80);
        rd(16'hB050, 16'hDF80);
        ext_live <= 16'h0000;
        tk(1);
        rd(16'hB054, 16'hDF80);
        rd(16'hB054, 16'h0000);
        complete_run;
    end
endmodule : module_mgmt_ext_regs_tb
